// File: design/address_map_consts.vh
// Address map boundaries and timing-free constants for the address decoder.
// Assumes 24-bit byte addresses and is included by its bare name.
`ifndef ADDRESS_MAP_CONSTS_VH
`define ADDRESS_MAP_CONSTS_VH
`define AW 24
`define SEG_BIT 16
`define PAGE_BIT 14
`define EXT_LO_START 24'h000000
`define EXT_LO_END 24'h007fff
`define DATA_SRAM_START 24'h008000
`define DATA_SRAM_END 24'h00dfff
`define EXTERNAL_SPECIAL_REGISTER_AREA_START 24'h00e000
`define EXTERNAL_SPECIAL_REGISTER_AREA_END 24'h00efff
`define EXTENDED_SPECIAL_REGISTER_AREA_START 24'h00f000
`define EXTENDED_SPECIAL_REGISTER_AREA_END 24'h00f1ff
`define RSV_DP_START 24'h00f200
`define RSV_DP_END 24'h00f5ff
`define DUAL_PORT_RAM_START 24'h00f600
`define DUAL_PORT_RAM_END 24'h00fdff
`define DUAL_PORT_RAM_BIT_START 24'h00fd00
`define SFR_START 24'h00fe00
`define SFR_END 24'h00ffff
`define EXT_MID_START 24'h010000
`define EXT_MID_END 24'h1fffff
`define CAN_START 24'h200000
`define CAN_END 24'h203fff
`define SER_START 24'h204000
`define SER_END 24'h2067ff
`define CANALT_START 24'h208000
`define CANALT_END 24'h20afff
`define SERALT_START 24'h20b000
`define SERALT_END 24'h20bfff
`define EXTIO_START 24'h210000
`define EXTIO_END 24'h3fffff
`define EXT_HI_START 24'h400000
`define EXT_HI_END 24'hbfffff
`define FLASH_START 24'hc00000
`define FLASH_MOD_BIT 18
`define FLASH6_START 24'hd80000
`define FLASH6_END 24'hd8ffff
`define FLASH_RSV_START 24'hc0f000
`define FLASH_RSV_END 24'hc0ffff
`define PROGRAM_SRAM_START 24'he00000
`define PROGRAM_SRAM_END 24'he1bfff
`define EMULATED_PROGRAM_SRAM_START 24'he80000
`define EMULATED_PROGRAM_SRAM_END 24'he9bfff
`define IMB_START 24'hffff00
`define IMB_END 24'hffffff
`define SECTOR_BIT 12
`define PROG_BLOCK_BIT 7
`define FLASH_WORD_BITS 128
// Target codes.
`define T_EXT 4'h0
`define T_DATA_SRAM 4'h1
`define T_EXTERNAL_SPECIAL_REGISTER_AREA 4'h2
`define T_EXTENDED_SPECIAL_REGISTER_AREA 4'h3
`define T_DUAL_PORT_RAM 4'h4
`define T_SFR 4'h5
`define T_PERIPH 4'h6
`define T_FLASH 4'h7
`define T_PROGRAM_SRAM 4'h8
`define T_EMULATED_PROGRAM_SRAM 4'h9
`define T_IMB 4'ha
`define T_NONE 4'hf
`endif

// File: design/address_map_decoder.v
// Address decoder and router for a 24-bit linear address space.
// Assumes fetch and data requesters present one-cycle request pulses with
// an address, and that flash protection state arrives as plain inputs.
`include "address_map_consts.vh"

module address_map_decoder #(
  parameter EXT_BUS_PRESENT = 1,
  parameter PROGRAM_SRAM_PROT_W = 17
) (
  input wire clk,
  input wire rstn,
  input wire fetch_req,
  input wire [23:0] fetch_addr,
  input wire data_req,
  input wire [23:0] data_addr,
  input wire data_write,
  input wire data_word,
  input wire data_bit,
  input wire [PROGRAM_SRAM_PROT_W-1:0] program_sram_prot_size,
  input wire [63:0] sector_wprot,
  input wire flash_read_prot,
  input wire flash_unlocked,
  input wire [6:0] flash_busy,
  output reg fetch_ack_q,
  output reg [3:0] fetch_target_q,
  output reg [23:0] fetch_ext_addr_q,
  output reg fetch_error_q,
  output reg [2:0] fetch_flash_mod_q,
  output reg fetch_ecc_q,
  output reg data_ack_q,
  output reg [3:0] data_target_q,
  output reg [23:0] data_ext_addr_q,
  output reg data_error_q,
  output reg data_word_q,
  output reg data_bit_ok_q,
  output reg data_via_sysbus_q,
  output reg [2:0] data_flash_mod_q,
  output reg data_ecc_q,
  output reg data_extio_q,
  output reg [7:0] data_segment_q,
  output reg [1:0] data_page_q,
  output reg [7:0] flash_sector_q,
  output reg [6:0] flash_block_q
);

  function in_rng;
    input [23:0] a;
    input [23:0] lo;
    input [23:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  // Region decode with fixed bounds; first match wins so each address has
  // exactly one target. Anything unmatched is reserved.
  function [3:0] decode;
    input [23:0] a;
    begin
      if (a[23:`SEG_BIT] == 8'h00) begin
        if (in_rng(a, `DATA_SRAM_START, `DATA_SRAM_END))
          decode = `T_DATA_SRAM;
        else if (in_rng(a, `EXTERNAL_SPECIAL_REGISTER_AREA_START, `EXTERNAL_SPECIAL_REGISTER_AREA_END))
          decode = `T_EXTERNAL_SPECIAL_REGISTER_AREA;
        else if (in_rng(a, `EXTENDED_SPECIAL_REGISTER_AREA_START, `EXTENDED_SPECIAL_REGISTER_AREA_END))
          decode = `T_EXTENDED_SPECIAL_REGISTER_AREA;
        else if (in_rng(a, `DUAL_PORT_RAM_START, `DUAL_PORT_RAM_END))
          decode = `T_DUAL_PORT_RAM;
        else if (in_rng(a, `SFR_START, `SFR_END))
          decode = `T_SFR;
        else if (in_rng(a, `EXT_LO_START, `EXT_LO_END))
          decode = `T_EXT;
        else
          decode = `T_NONE;
      end else if (in_rng(a, `EXT_MID_START, `EXT_MID_END))
        decode = `T_EXT;
      else if (in_rng(a, `CAN_START, `CAN_END) ||
               in_rng(a, `SER_START, `SER_END) ||
               in_rng(a, `CANALT_START, `CANALT_END) ||
               in_rng(a, `SERALT_START, `SERALT_END))
        decode = `T_PERIPH;
      else if (in_rng(a, `EXTIO_START, `EXT_HI_END))
        decode = `T_EXT;
      else if (in_rng(a, `FLASH_START, `FLASH6_END))
        decode = `T_FLASH;
      else if (in_rng(a, `PROGRAM_SRAM_START, `PROGRAM_SRAM_END))
        decode = `T_PROGRAM_SRAM;
      else if (in_rng(a, `EMULATED_PROGRAM_SRAM_START, `EMULATED_PROGRAM_SRAM_END))
        decode = `T_EMULATED_PROGRAM_SRAM;
      else if (in_rng(a, `IMB_START, `IMB_END))
        decode = `T_IMB;
      else
        decode = `T_NONE;
    end
  endfunction

  // Flash module index: modules 0..5 are 256 KB each, module 6 is 64 KB.
  function [2:0] flash_mod;
    input [23:0] a;
    reg [23:0] off;
    begin
      off = a - `FLASH_START;
      flash_mod = off[20:`FLASH_MOD_BIT];
    end
  endfunction

  wire [3:0] f_t = decode(fetch_addr);
  wire [3:0] d_t = decode(data_addr);
  wire f_rsv_flash = in_rng(fetch_addr, `FLASH_RSV_START, `FLASH_RSV_END);
  wire d_rsv_flash = in_rng(data_addr, `FLASH_RSV_START, `FLASH_RSV_END);
  wire [23:0] d_flash_off = data_addr - `FLASH_START;
  wire [5:0] d_sector = d_flash_off[17:`SECTOR_BIT];
  wire [2:0] d_mod = flash_mod(data_addr);
  wire [2:0] f_mod = flash_mod(fetch_addr);
  // Sector protection index; clusters share bits, so several sectors map
  // onto one protection bit while erase and program stay per sector.
  wire [5:0] d_cluster = {d_mod, d_sector[5:3]};
  wire [23:0] program_sram_off = data_addr - `PROGRAM_SRAM_START;
  wire [23:0] prot_lim = {{(24-PROGRAM_SRAM_PROT_W){1'b0}}, program_sram_prot_size};
  wire d_program_sram_wp = (d_t == `T_PROGRAM_SRAM) && data_write &&
                    (program_sram_off < prot_lim);
  wire f_rd_block = flash_read_prot && !flash_unlocked;
  wire d_flash_wp = (d_t == `T_FLASH) && data_write &&
                    sector_wprot[d_cluster];
  wire d_err = ((d_t == `T_NONE) && (EXT_BUS_PRESENT == 0)) ||
               ((d_t == `T_FLASH) && (d_rsv_flash ||
                (!data_write && f_rd_block))) ||
               d_program_sram_wp || d_flash_wp ||
               (data_bit && !((d_t == `T_SFR) || (d_t == `T_EXTENDED_SPECIAL_REGISTER_AREA) ||
                (d_t == `T_DUAL_PORT_RAM)));
  wire f_err = ((f_t == `T_NONE) && (EXT_BUS_PRESENT == 0)) ||
               ((f_t == `T_FLASH) && (f_rsv_flash || f_rd_block)) ||
               (f_t == `T_DATA_SRAM) || (f_t == `T_EXTERNAL_SPECIAL_REGISTER_AREA) ||
               (f_t == `T_EXTENDED_SPECIAL_REGISTER_AREA) || (f_t == `T_SFR) ||
               (f_t == `T_DUAL_PORT_RAM) || (f_t == `T_IMB);
  // Bit access reaches the upper 256 bytes of the dual-port RAM, the SFR area
  // and the extended special register area; other dual-port words only via register-bank addressing.
  wire d_bit_ok = (d_t == `T_SFR) || (d_t == `T_EXTENDED_SPECIAL_REGISTER_AREA) ||
                  ((d_t == `T_DUAL_PORT_RAM) &&
                   (data_addr >= `DUAL_PORT_RAM_BIT_START));
  // Data accesses to program memories and external/peripheral space cross
  // the system bus; the fetch side does its own work in parallel.
  wire d_sys = (d_t == `T_FLASH) || (d_t == `T_PROGRAM_SRAM) ||
               (d_t == `T_EMULATED_PROGRAM_SRAM) || (d_t == `T_EXT) ||
               (d_t == `T_PERIPH) || (d_t == `T_NONE);

  function [3:0] route;
    input [3:0] t;
    begin
      if ((t == `T_NONE) && (EXT_BUS_PRESENT != 0))
        route = `T_EXT;
      else
        route = t;
    end
  endfunction

  always @(posedge clk) begin
    if (!rstn) begin
      fetch_ack_q <= 1'b0;
      fetch_target_q <= `T_NONE;
      fetch_ext_addr_q <= 24'h000000;
      fetch_error_q <= 1'b0;
      fetch_flash_mod_q <= 3'h0;
      fetch_ecc_q <= 1'b0;
    end else begin
      fetch_ack_q <= fetch_req;
      fetch_error_q <= fetch_req && f_err;
      fetch_ecc_q <= fetch_req && (f_t == `T_FLASH) && !f_err;
      if (fetch_req) begin
        fetch_target_q <= route(f_t);
        fetch_ext_addr_q <= fetch_addr;
        fetch_flash_mod_q <= f_mod;
      end
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      data_ack_q <= 1'b0;
      data_target_q <= `T_NONE;
      data_ext_addr_q <= 24'h000000;
      data_error_q <= 1'b0;
      data_word_q <= 1'b0;
      data_bit_ok_q <= 1'b0;
      data_via_sysbus_q <= 1'b0;
      data_flash_mod_q <= 3'h0;
      data_ecc_q <= 1'b0;
      data_extio_q <= 1'b0;
      data_segment_q <= 8'h00;
      data_page_q <= 2'h0;
      flash_sector_q <= 8'h00;
      flash_block_q <= 7'h00;
    end else begin
      data_ack_q <= data_req;
      data_error_q <= data_req && d_err;
      data_ecc_q <= data_req && (d_t == `T_FLASH) && !data_write &&
                    !d_err;
      data_extio_q <= data_req &&
                      in_rng(data_addr, `EXTIO_START, `EXTIO_END);
      data_bit_ok_q <= data_req && data_bit && d_bit_ok;
      data_via_sysbus_q <= data_req && d_sys;
      if (data_req) begin
        data_target_q <= route(d_t);
        data_ext_addr_q <= data_addr;
        data_word_q <= data_word;
        data_segment_q <= data_addr[23:`SEG_BIT];
        data_page_q <= data_addr[`SEG_BIT-1:`PAGE_BIT];
        data_flash_mod_q <= d_mod;
        flash_sector_q <= {2'b00, d_sector};
        flash_block_q <= {2'b00, d_flash_off[`SECTOR_BIT-1:
                         `PROG_BLOCK_BIT]};
      end
    end
  end

endmodule

// File: test/address_map_decoder_properties.sv
// Checker for the address decoder's request, routing and flag ports.
// Assumes it is bound to the decoder and sees only the decoder's ports.
`include "address_map_consts.vh"
module address_map_decoder_properties #(
  parameter EXT_BUS_PRESENT = 1,
  parameter PROGRAM_SRAM_PROT_W = 17
) (
  input wire clk,
  input wire rstn,
  input wire fetch_req,
  input wire data_req,
  input wire [23:0] data_addr,
  input wire data_bit,
  input wire fetch_ack_q,
  input wire data_ack_q,
  input wire [3:0] data_target_q,
  input wire data_error_q,
  input wire data_bit_ok_q,
  input wire data_extio_q,
  input wire [7:0] data_segment_q,
  input wire [1:0] data_page_q,
  input wire data_word,
  input wire data_word_q,
  input wire data_via_sysbus_q,
  input wire [2:0] data_flash_mod_q,
  input wire [7:0] flash_sector_q,
  input wire [6:0] flash_block_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // The address is kept one cycle so its fields can be sliced later.
  logic [23:0] prev_addr;
  always @(posedge clk) prev_addr <= data_addr;
  AST_DATA_ACK: assert property (data_req |=> data_ack_q)
    else $error("data request not answered next cycle");
  AST_FETCH_ACK: assert property (fetch_ack_q == $past(fetch_req))
    else $error("fetch answer not one cycle after request");
  AST_DATA_SRAM: assert property (data_req && data_addr inside
    {[`DATA_SRAM_START:`DATA_SRAM_END]} |=> data_target_q == `T_DATA_SRAM)
    else $error("data sram address not routed to data sram");
  AST_RSV_EXT: assert property (data_req && EXT_BUS_PRESENT != 0 &&
    data_addr inside {[24'h20c000:24'h20ffff], [`RSV_DP_START:`RSV_DP_END]}
    |=> data_target_q == `T_EXT && !data_error_q)
    else $error("reserved address not sent to external bus");
  AST_FLASH_RSV: assert property (data_req && data_addr inside
    {[`FLASH_RSV_START:`FLASH_RSV_END]} |=> data_error_q)
    else $error("internal flash sector not refused");
  AST_EXTIO: assert property (data_req |=> data_extio_q ==
    (prev_addr inside {[`EXTIO_START:`EXTIO_END]}))
    else $error("external io flag wrong");
  AST_BIT: assert property (data_req && data_bit && data_addr inside
    {[`DUAL_PORT_RAM_BIT_START:`DUAL_PORT_RAM_END]} |=> data_bit_ok_q && !data_error_q)
    else $error("bit access to top of dual port ram refused");
  AST_SEG: assert property (data_req |=>
    data_segment_q == prev_addr[23:16] && data_page_q == prev_addr[15:14])
    else $error("segment or page field wrong");
  AST_WORD: assert property (data_req |=> data_word_q == $past(data_word))
    else $error("access size not carried");
  AST_SYSBUS: assert property (data_req && data_addr inside
    {[`EXT_HI_START:`EXT_HI_END]} |=> data_via_sysbus_q)
    else $error("external data access not sent over system bus");
  // Flash starts on a boundary whose bits 20 to 0 are clear, so module,
  // sector and block are plain slices of the address.
  AST_FLASH_MOD: assert property (data_req && data_addr inside
    {[`FLASH_START:`FLASH6_END]} |=> data_flash_mod_q == prev_addr[20:18])
    else $error("flash module index wrong");
  AST_SECTOR: assert property (data_req && data_addr inside
    {[`FLASH_START:`FLASH6_END]} |=>
    flash_sector_q == {2'b00, prev_addr[17:12]} &&
    flash_block_q == {2'b00, prev_addr[11:7]})
    else $error("flash sector or block wrong");
  cover property (data_req && data_bit);
  cover property (data_req && fetch_req);
  cover property (data_ack_q && data_error_q);
endmodule

bind address_map_decoder address_map_decoder_properties #(
  .EXT_BUS_PRESENT(EXT_BUS_PRESENT), .PROGRAM_SRAM_PROT_W(PROGRAM_SRAM_PROT_W)) i_props (
  .clk(clk), .rstn(rstn), .fetch_req(fetch_req), .data_req(data_req),
  .data_addr(data_addr), .data_bit(data_bit), .fetch_ack_q(fetch_ack_q),
  .data_ack_q(data_ack_q), .data_target_q(data_target_q),
  .data_error_q(data_error_q), .data_bit_ok_q(data_bit_ok_q),
  .data_extio_q(data_extio_q), .data_segment_q(data_segment_q),
  .data_page_q(data_page_q), .data_word(data_word),
  .data_word_q(data_word_q), .data_via_sysbus_q(data_via_sysbus_q),
  .data_flash_mod_q(data_flash_mod_q), .flash_sector_q(flash_sector_q),
  .flash_block_q(flash_block_q));

// File: test/fetch_requester.sv
// Fetch-side requester: turns a bench command into a one-cycle fetch pulse.
// Assumes the bench drives issue and issue_addr just after a rising edge.
module fetch_requester (
  input wire clk,
  input wire rstn,
  input wire issue,
  input wire [23:0] issue_addr,
  output logic fetch_req,
  output logic [23:0] fetch_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Between requests the address keeps changing, so a decoder that reads
  // a stale address is caught.
  always @(posedge clk) begin
    fetch_req <= rstn && issue;
    fetch_addr <= !rstn ? 24'h000000 : issue ? issue_addr : ~fetch_addr;
  end
endmodule

// File: test/address_map_decoder_tb.sv
// Self-checking bench for the address decoder: routing and errors.
// Assumes the decoder, its bound checker and the fetch requester model.
module address_map_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, data_req = 0, data_write = 0, data_word = 0;
  logic data_bit = 0, fetch_issue = 0, read_prot = 0, unlocked = 0;
  logic [23:0] data_addr = 0, issue_addr = 0;
  logic [16:0] prot_size = 17'h00100;
  logic [63:0] wprot = 0;
  logic [6:0] busy = 0;
  logic [31:0] seed = 32'h00000012;
  logic [87:0] tt = 88'h7a987f70006666054032_10;
  logic [23:0] ta [22] = '{24'h000000, 24'h008000, 24'h00e000, 24'h00f000,
    24'h00f200, 24'h00f600, 24'h00fe00, 24'h1fff00, 24'h200000, 24'h204000,
    24'h208000, 24'h20b000, 24'h20c000, 24'h210000, 24'h400000, 24'hc00000,
    24'hc0f000, 24'hd80000, 24'he00000, 24'he80000, 24'hffff00, 24'hc40000};
  logic [23:0] fa [3] = '{24'hc00000, 24'h008000, 24'he00010};
  logic [4:0] fe [3] = '{5'h0e, 5'h1f, 5'h10};
  logic [4:0] dq [$], fq [$];
  int miscompares = 0, samples_checked = 0;
  wire fetch_req, d_ack, d_err, f_ack, f_err;
  wire [23:0] fetch_addr;
  wire [3:0] d_tgt, f_tgt;
  always #50 clk = ~clk;
  fetch_requester i_req (.clk(clk), .rstn(rstn), .issue(fetch_issue),
    .issue_addr(issue_addr), .fetch_req(fetch_req), .fetch_addr(fetch_addr));
  address_map_decoder #(.EXT_BUS_PRESENT(1), .PROGRAM_SRAM_PROT_W(17)) i_dut (
    .clk(clk), .rstn(rstn), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .data_req(data_req), .data_addr(data_addr), .data_write(data_write),
    .data_word(data_word), .data_bit(data_bit), .program_sram_prot_size(prot_size),
    .sector_wprot(wprot), .flash_read_prot(read_prot),
    .flash_unlocked(unlocked), .flash_busy(busy), .fetch_ack_q(f_ack),
    .fetch_target_q(f_tgt), .fetch_ext_addr_q(), .fetch_error_q(f_err),
    .fetch_flash_mod_q(), .fetch_ecc_q(), .data_ack_q(d_ack),
    .data_target_q(d_tgt), .data_ext_addr_q(), .data_error_q(d_err),
    .data_word_q(), .data_bit_ok_q(), .data_via_sysbus_q(),
    .data_flash_mod_q(), .data_ecc_q(), .data_extio_q(), .data_segment_q(),
    .data_page_q(), .flash_sector_q(), .flash_block_q());
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [4:0] te(int i);
    return {tt[4*i +: 4], tt[4*i +: 4] == 4'hf};
  endfunction
  // A target code of f in the note means only the error bit is compared.
  task automatic chk(string n, logic [4:0] e, logic [4:0] g);
    samples_checked++;
    if ((e[4:1] != 4'hf && g[4:1] !== e[4:1]) || g[0] !== e[0]) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Word or byte size is random; either must be accepted anywhere.
  task automatic dreq(logic [23:0] a, logic w, logic b, logic [1:0] p,
    logic [4:0] e);
    @(posedge clk);
    seed = xs(seed);
    data_req <= 1'b1;
    data_addr <= a;
    data_write <= w;
    data_bit <= b;
    {read_prot, unlocked} <= p;
    data_word <= seed[0];
    busy <= seed[7:1];
    wprot <= {seed, ~seed};
    dq.push_back(e);
  endtask
  task automatic freq(logic [23:0] a, logic [4:0] e);
    @(posedge clk);
    fetch_issue <= 1'b1;
    issue_addr <= a;
    fq.push_back(e);
  endtask
  task automatic finish_test;
    if (dq.size() + fq.size() != 0) miscompares++;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (d_ack === 1'b1) begin
      chk("data", dq.pop_front(), {d_tgt, d_err});
    end
  end
  always @(posedge clk) begin
    if (f_ack === 1'b1) begin
      chk("fetch", fq.pop_front(), {f_tgt, f_err});
    end
  end
  initial begin
    #(600 * 100);
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    chk("reset", 5'h1e, {d_tgt, d_err});
    rstn <= 1'b1;
    fork
      for (int i = 0; i < 22; i++) begin
        dreq(ta[i] | 24'(seed[7:0]), 0, 0, 2'b00, te(i));
      end
      begin
        for (int i = 0; i < 3; i++) freq(fa[i], fe[i]);
        @(posedge clk);
        fetch_issue <= 1'b0;
      end
    join
    dreq(24'h00fd10, 0, 1, 2'b00, 5'h08);
    dreq(24'h008010, 0, 1, 2'b00, 5'h1f);
    dreq(24'h00fe20, 0, 1, 2'b00, 5'h0a);
    dreq(24'h00f010, 0, 1, 2'b00, 5'h06);
    // Software only touches register addresses that are in use.
    dreq(24'h00fe20, 1, 0, 2'b00, 5'h0a);
    dreq(24'he000fe, 1, 0, 2'b00, 5'h11);
    dreq(24'he00100, 1, 0, 2'b00, 5'h10);
    dreq(24'hc40000, 0, 0, 2'b10, 5'h1f);
    dreq(24'hc40000, 0, 0, 2'b11, 5'h0e);
    @(posedge clk);
    data_req <= 1'b0;
    repeat (4) @(posedge clk);
    finish_test;
  end
endmodule
